// *** src/sfspi_pkg.sv ***
package sfspi_pkg;
	localparam logic [7:0] OP_WRITE_STATUS = 8'h01;
	localparam logic [7:0] OP_PAGE_PROGRAM = 8'h02;
	localparam logic [7:0] OP_READ_DATA    = 8'h03;
	localparam logic [7:0] OP_WRITE_DIS    = 8'h04;
	localparam logic [7:0] OP_READ_STATUS  = 8'h05;
	localparam logic [7:0] OP_WRITE_EN     = 8'h06;
	localparam logic [7:0] OP_FAST_READ    = 8'h0B;
	localparam logic [7:0] OP_SECTOR_ERASE = 8'h20;
	localparam logic [7:0] OP_DUAL_READ    = 8'h3B;
	localparam logic [7:0] OP_CHIP_ERASE   = 8'hC7;
	localparam logic [7:0] OP_BLOCK_ERASE  = 8'hD8;
	localparam logic [7:0] OP_POWER_DOWN   = 8'hB9;
	localparam logic [7:0] OP_RELEASE_PD   = 8'hAB;
	localparam int         BUSY_POS        = 0;
	localparam int         WLATCH_POS      = 1;
	localparam int         RANGE_LO        = 2;
	localparam int         RANGE_HI        = 4;
	localparam int         LOW_END_POS     = 5;
	localparam int         LOCK_POS        = 7;
	localparam logic [7:0] STATUS_RESET    = 8'h00;
	localparam int         SYS_CLK_HZ      = 50_000_000;
	localparam int         PUW_US          = 10;
	localparam int         PUW_CYCLES      = (PUW_US * (SYS_CLK_HZ / 1_000_000));
	localparam int         WRITE_NS        = 1000;
	localparam int         WRITE_CYCLES    = (WRITE_NS + 19) / 20;
	localparam int         SYNC_SETTLE     = 3;
	typedef enum logic [2:0] {
		SFSPI_IDLE   = 3'b000,
		SFSPI_OPCODE = 3'b001,
		SFSPI_ARGS   = 3'b010,
		SFSPI_DATA   = 3'b011,
		SFSPI_DONE   = 3'b100
	} sfspi_state_t;
endpackage : sfspi_pkg

// *** src/sfspi_sync.sv ***
`timescale 1ns/10ps
module sfspi_sync #(
	parameter int WIDTH = 4
) (
	input  wire logic             sys_clk,
	input  wire logic             rst,
	input  wire logic [WIDTH-1:0] async_in,
	input  wire logic [WIDTH-1:0] reset_val,
	output logic      [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] stage1_ff;
	// Shows all ones in reset, then reset_val until stage one holds a pin sample
	logic             released_ff;

	if (WIDTH < 1) begin : g_width_check
		$error("sfspi_sync: width must be at least one");
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			stage1_ff   <= '1;
			sync_out    <= '1;
			released_ff <= 1'b0;
		end else begin
			stage1_ff   <= async_in;
			sync_out    <= released_ff ? stage1_ff : reset_val;
			released_ff <= 1'b1;
		end
	end
endmodule : sfspi_sync

// *** src/sfspi_front.sv ***
// Behaviour
// - Deselected: output released, internal writes continue
// - First instruction needs a select falling edge
// - Sample input bit on clock rising edge
// - Shift outputs on clock falling edge
// - Modes 0 and 3 both supported
// - Dual read drives io pin too
// - Other instructions: io pin input only
// - Pause only when selected; outputs released, ignored
// - Pause starts at hold fall or clock fall
// - Pause ends at hold rise or clock fall
// - Pause keeps partial instruction state
// - Reset disables all, no instruction recognised
// - Write instructions ignored during power-up delay
// - Write latch cleared at power-up
// - Writes rejected unless write latch set
// - Write latch clears when write completes
// - Protect pin low with lock blocks status writes
// - Range bits and low-end bit stored only, not checked against addresses
// - Power-down ignores all but release
// - Status read reports busy, latch, protection
// - Busy bit 0; busy ignores all but status read
// - Write latch bit 1; enable sets, disable clears
// - Lock bit 7 blocks status write when pin low
// - Range bits 4..2; low-end selects bottom
`timescale 1ns/10ps
module sfspi_front
	import sfspi_pkg::*;
#(
	parameter int PUW_CYC   = sfspi_pkg::PUW_CYCLES,
	parameter int WRITE_CYC = sfspi_pkg::WRITE_CYCLES,
	parameter int ADDR_BITS = 24
) (
	input  wire logic        sys_clk,
	input  wire logic        rst,
	input  wire logic        chip_select_n,
	input  wire logic        serial_clk,
	input  wire logic        bus_pause_n,
	input  wire logic        write_protect_n,
	input  wire logic        serial_io_in,
	output logic             serial_io_out,
	output logic             serial_io_oe,
	output logic             serial_out_pin,
	output logic             serial_out_oe,
	input  wire logic [7:0]  array_rd_data,
	output logic [23:0]      array_addr,
	output logic             array_rd_strobe,
	output logic [7:0]       array_wr_data,
	output logic             array_wr_strobe,
	output logic [7:0]       status_ff,
	output logic             powered_down_ff,
	output logic [7:0]       opcode_ff,
	output logic             paused_ff,
	output logic             write_start_ff
);
	import sfspi_pkg::*;

	if (ADDR_BITS != 24 || PUW_CYC < 1 || WRITE_CYC < 1) begin : g_param_check
		$error("sfspi_front: unsupported parameter value");
	end

	function automatic logic is_write_op(input logic [7:0] op);
		return op == OP_PAGE_PROGRAM || op == OP_SECTOR_ERASE || op == OP_BLOCK_ERASE ||
			op == OP_CHIP_ERASE || op == OP_WRITE_STATUS;
	endfunction : is_write_op

	function automatic logic is_read_op(input logic [7:0] op);
		return op == OP_READ_DATA || op == OP_FAST_READ || op == OP_DUAL_READ;
	endfunction : is_read_op

	// Two-flop synchronisers for all pins
	logic [4:0] pins_s;
	sfspi_sync #(.WIDTH(5)) u_sync (
		.sys_clk   (sys_clk),
		.rst       (rst),
		.async_in  ({chip_select_n, serial_clk, bus_pause_n, write_protect_n, serial_io_in}),
		.reset_val (5'h1F),
		.sync_out  (pins_s)
	);
	logic cs_n_s, sck_s, hold_n_s, wp_n_s, io_s;
	assign cs_n_s   = pins_s[4];
	assign sck_s    = pins_s[3];
	assign hold_n_s = pins_s[2];
	assign wp_n_s   = pins_s[1];
	assign io_s     = pins_s[0];

	logic       sck_d_ff, cs_d_ff;
	logic [1:0] settle_ff;
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			sck_d_ff  <= 1'b1;
			cs_d_ff   <= 1'b1;
			settle_ff <= 2'd0;
		end else begin
			sck_d_ff  <= sck_s;
			cs_d_ff   <= cs_n_s;
			if (settle_ff != 2'(SYNC_SETTLE))
				settle_ff <= settle_ff + 2'd1;
		end
	end
	logic sck_rise, sck_fall, cs_fall, cs_rise;
	assign sck_rise = sck_s & ~sck_d_ff;
	assign sck_fall = ~sck_s & sck_d_ff;
	assign cs_fall  = ~cs_n_s & cs_d_ff;
	assign cs_rise  = cs_n_s & ~cs_d_ff;

	// Arming: select must fall after reset
	logic armed_ff;
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst)
			armed_ff <= 1'b0;
		else if (cs_fall && settle_ff == 2'(SYNC_SETTLE))
			armed_ff <= 1'b1;
	end

	// Power-up write delay
	logic [$clog2(PUW_CYC+1)-1:0] puw_cnt_ff;
	logic                         puw_done_ff;
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			puw_cnt_ff  <= '0;
			puw_done_ff <= 1'b0;
		end else if (!puw_done_ff) begin
			puw_cnt_ff <= puw_cnt_ff + 1'b1;
			if (puw_cnt_ff == ($clog2(PUW_CYC+1))'(PUW_CYC - 1))
				puw_done_ff <= 1'b1;
		end
	end

	// Pause tracking
	logic nxt_paused;
	always_comb begin
		nxt_paused = paused_ff;
		if (cs_n_s)
			nxt_paused = 1'b0;
		else if (!hold_n_s && !paused_ff && (!sck_s || sck_fall))
			nxt_paused = 1'b1;
		else if (hold_n_s && paused_ff && (!sck_s || sck_fall))
			nxt_paused = 1'b0;
	end
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst)
			paused_ff <= 1'b0;
		else
			paused_ff <= nxt_paused;
	end

	logic active;
	assign active = armed_ff & ~cs_n_s & ~paused_ff & ~nxt_paused;

	// Transfer state
	sfspi_state_t state_ff;
	logic [2:0]   bit_cnt_ff;
	logic [7:0]   shift_ff;
	logic [1:0]   arg_cnt_ff;
	logic [7:0]   tx_ff;
	logic         dual_ff;
	logic         dummy_ff;

	logic [7:0] shift_in;
	logic       byte_done;
	assign shift_in  = {shift_ff[6:0], io_s};
	assign byte_done = active & sck_rise & (bit_cnt_ff == 3'd7);

	logic busy, wlatch, locked;
	assign busy   = status_ff[BUSY_POS];
	assign wlatch = status_ff[WLATCH_POS];
	assign locked = status_ff[LOCK_POS] & ~wp_n_s;

	// Opcode gating per mode
	function automatic logic op_allowed(input logic [7:0] op, input logic pd,
		input logic bsy, input logic puw);
		if (pd)
			return op == OP_RELEASE_PD;
		if (bsy)
			return op == OP_READ_STATUS;
		if (!puw && (is_write_op(op) || op == OP_WRITE_EN))
			return 1'b0;
		return 1'b1;
	endfunction : op_allowed

	logic [7:0] last_byte_ff;
	logic       byte_evt_ff;
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			state_ff     <= SFSPI_IDLE;
			bit_cnt_ff   <= '0;
			shift_ff     <= '0;
			arg_cnt_ff   <= '0;
			opcode_ff    <= '0;
			array_addr   <= '0;
			dual_ff      <= 1'b0;
			dummy_ff     <= 1'b0;
			last_byte_ff <= '0;
			byte_evt_ff  <= 1'b0;
		end else begin
			byte_evt_ff <= 1'b0;
			if (cs_n_s || !armed_ff) begin
				state_ff   <= SFSPI_IDLE;
				bit_cnt_ff <= '0;
				dual_ff    <= 1'b0;
			end else if (state_ff == SFSPI_IDLE) begin
				state_ff <= SFSPI_OPCODE;
			end else if (active && sck_rise && !dual_ff) begin
				shift_ff   <= shift_in;
				bit_cnt_ff <= bit_cnt_ff + 3'd1;
				if (byte_done) begin
					last_byte_ff <= shift_in;
					byte_evt_ff  <= 1'b1;
					unique case (state_ff)
						SFSPI_OPCODE: begin
							opcode_ff  <= shift_in;
							arg_cnt_ff <= 2'd0;
							if (!op_allowed(shift_in, powered_down_ff, busy, puw_done_ff))
								state_ff <= SFSPI_DONE;
							else if (is_read_op(shift_in) || shift_in == OP_PAGE_PROGRAM ||
								shift_in == OP_SECTOR_ERASE || shift_in == OP_BLOCK_ERASE)
								state_ff <= SFSPI_ARGS;
							else if (shift_in == OP_READ_STATUS || shift_in == OP_WRITE_STATUS)
								state_ff <= SFSPI_DATA;
							else
								state_ff <= SFSPI_DONE;
						end
						SFSPI_ARGS: begin
							array_addr <= {array_addr[15:0], shift_in};
							arg_cnt_ff <= arg_cnt_ff + 2'd1;
							if (arg_cnt_ff == 2'd2) begin
								dummy_ff <= opcode_ff == OP_FAST_READ || opcode_ff == OP_DUAL_READ;
								state_ff <= SFSPI_DATA;
							end
						end
						SFSPI_DATA: begin
							if (dummy_ff) begin
								dummy_ff <= 1'b0;
								dual_ff  <= opcode_ff == OP_DUAL_READ;
							end else if (opcode_ff == OP_PAGE_PROGRAM) begin
								array_addr[7:0] <= array_addr[7:0] + 8'd1;
							end else if (is_read_op(opcode_ff)) begin
								array_addr <= array_addr + 24'd1;
							end
						end
						SFSPI_DONE: begin
						end
						default: state_ff <= SFSPI_DONE;
					endcase
				end
			end else if (active && sck_rise && dual_ff) begin
				bit_cnt_ff <= bit_cnt_ff + 3'd2;
				if (bit_cnt_ff == 3'd6)
					array_addr <= array_addr + 24'd1;
			end
		end
	end

	// Output shifter, changes on clock fall
	logic read_phase;
	assign read_phase = (state_ff == SFSPI_DATA) && !dummy_ff &&
		(is_read_op(opcode_ff) || opcode_ff == OP_READ_STATUS);
	logic [7:0] tx_src;
	assign tx_src = (bit_cnt_ff != 3'd0) ? tx_ff :
		(opcode_ff == OP_READ_STATUS) ? status_ff : array_rd_data;
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			tx_ff           <= '0;
			serial_out_pin  <= 1'b0;
			serial_io_out   <= 1'b0;
			array_rd_strobe <= 1'b0;
		end else begin
			array_rd_strobe <= read_phase && active && bit_cnt_ff == 3'd0 && sck_rise;
			if (active && sck_fall && read_phase) begin
				tx_ff <= tx_src;
				if (dual_ff) begin
					serial_io_out  <= tx_src[7 - bit_cnt_ff];
					serial_out_pin <= tx_src[6 - bit_cnt_ff];
				end else begin
					serial_out_pin <= tx_src[7 - bit_cnt_ff];
				end
			end
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			serial_out_oe <= 1'b0;
			serial_io_oe  <= 1'b0;
		end else begin
			serial_out_oe <= ~cs_n_s & ~nxt_paused & read_phase;
			serial_io_oe  <= ~cs_n_s & ~nxt_paused & read_phase & dual_ff;
		end
	end

	// Instruction execution at select rise
	logic [$clog2(WRITE_CYC+1)-1:0] wr_cnt_ff;
	logic exec;
	assign exec = cs_rise && armed_ff && !paused_ff;
	logic data_seen_ff;
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst)
			data_seen_ff <= 1'b0;
		else if (cs_fall)
			data_seen_ff <= 1'b0;
		else if (byte_evt_ff && state_ff == SFSPI_DATA)
			data_seen_ff <= 1'b1;
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			status_ff       <= STATUS_RESET;
			powered_down_ff <= 1'b0;
			write_start_ff  <= 1'b0;
			wr_cnt_ff       <= '0;
			array_wr_data   <= '0;
			array_wr_strobe <= 1'b0;
		end else begin
			write_start_ff  <= 1'b0;
			array_wr_strobe <= 1'b0;
			if (byte_evt_ff && state_ff == SFSPI_DATA && opcode_ff == OP_PAGE_PROGRAM &&
				wlatch && !dummy_ff) begin
				array_wr_data   <= last_byte_ff;
				array_wr_strobe <= 1'b1;
			end
			if (busy) begin
				if (wr_cnt_ff == ($clog2(WRITE_CYC+1))'(WRITE_CYC - 1)) begin
					status_ff[BUSY_POS]   <= 1'b0;
					status_ff[WLATCH_POS] <= 1'b0;
				end else begin
					wr_cnt_ff <= wr_cnt_ff + 1'b1;
				end
			end else if (exec && bit_cnt_ff == 3'd0 && state_ff != SFSPI_OPCODE) begin
				if (powered_down_ff) begin
					if (opcode_ff == OP_RELEASE_PD)
						powered_down_ff <= 1'b0;
				end else if (opcode_ff == OP_WRITE_EN && puw_done_ff) begin
					status_ff[WLATCH_POS] <= 1'b1;
				end else if (opcode_ff == OP_WRITE_DIS) begin
					status_ff[WLATCH_POS] <= 1'b0;
				end else if (opcode_ff == OP_POWER_DOWN) begin
					powered_down_ff <= 1'b1;
				end else if (is_write_op(opcode_ff) && wlatch && puw_done_ff) begin
					if (opcode_ff == OP_WRITE_STATUS) begin
						if (!locked && data_seen_ff) begin
							status_ff[LOCK_POS]            <= last_byte_ff[LOCK_POS];
							status_ff[LOW_END_POS]         <= last_byte_ff[LOW_END_POS];
							status_ff[RANGE_HI:RANGE_LO]   <= last_byte_ff[RANGE_HI:RANGE_LO];
							status_ff[BUSY_POS]            <= 1'b1;
							wr_cnt_ff                      <= '0;
						end
					end else if (opcode_ff != OP_PAGE_PROGRAM || data_seen_ff) begin
						status_ff[BUSY_POS] <= 1'b1;
						write_start_ff      <= 1'b1;
						wr_cnt_ff           <= '0;
					end
				end
			end
		end
	end
endmodule : sfspi_front

// *** test/sfspi_front_sva.sv ***
`timescale 1ns/10ps
module sfspi_front_sva #(
	parameter int PUW_CYC = sfspi_pkg::PUW_CYCLES
) (
	input wire logic       sys_clk,
	input wire logic       rst,
	input wire logic       chip_select_n,
	input wire logic       serial_clk,
	input wire logic       bus_pause_n,
	input wire logic       serial_io_oe,
	input wire logic       serial_out_oe,
	input wire logic [7:0] status_ff,
	input wire logic       powered_down_ff,
	input wire logic [7:0] opcode_ff,
	input wire logic       paused_ff,
	input wire logic       write_start_ff
);
	import sfspi_pkg::*;
	int unsigned up_cnt_ff;
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);
	// Cycles since reset release, saturating at the power-up write delay
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst)
			up_cnt_ff <= 0;
		else if (up_cnt_ff < PUW_CYC)
			up_cnt_ff <= up_cnt_ff + 1;
	end
	sequence hold_fall_low;
		$fell(bus_pause_n) && !serial_clk && !chip_select_n;
	endsequence
	sequence busy_run;
		status_ff[BUSY_POS] [*8];
	endsequence
	AST_DESEL_QUIET: assert property (chip_select_n [*6] |-> !serial_out_oe && !serial_io_oe)
		else $error("output enabled while deselected");
	AST_IO_DUAL_ONLY: assert property (serial_io_oe |-> opcode_ff == OP_DUAL_READ)
		else $error("io pin driven outside dual read");
	AST_PAUSE_QUIET: assert property (paused_ff [*2] |-> !serial_out_oe && !serial_io_oe)
		else $error("output enabled during pause");
	AST_PAUSE_SELECTED: assert property (chip_select_n [*6] |-> !paused_ff)
		else $error("pause while deselected");
	AST_PAUSE_START: assert property (hold_fall_low |-> ##[1:6] paused_ff)
		else $error("pause did not begin");
	AST_PAUSE_END: assert property ($rose(bus_pause_n) && !serial_clk && paused_ff |-> ##[1:6] !paused_ff)
		else $error("pause did not end");
	AST_RESET_CLEAR: assert property ($fell(rst) |-> status_ff == STATUS_RESET && !powered_down_ff)
		else $error("state not cleared by reset");
	AST_PUW_NO_LATCH: assert property (up_cnt_ff < PUW_CYC |-> !status_ff[WLATCH_POS])
		else $error("latch set inside power-up delay");
	AST_BUSY_HOLDS: assert property ($rose(status_ff[BUSY_POS]) |-> busy_run)
		else $error("busy too short");
	AST_WRITE_NEEDS_LATCH: assert property ($rose(status_ff[BUSY_POS]) |->
		$past(status_ff[WLATCH_POS], 1) || $past(status_ff[WLATCH_POS], 2))
		else $error("write started without latch");
	AST_LATCH_CLEARS: assert property ($fell(status_ff[BUSY_POS]) |-> ##[0:1] !status_ff[WLATCH_POS])
		else $error("latch kept after write");
	AST_PD_NO_LATCH: assert property (powered_down_ff && $past(powered_down_ff) |->
		!$rose(status_ff[WLATCH_POS]))
		else $error("latch set in power-down");
	AST_START_BUSY: assert property (write_start_ff |-> status_ff[BUSY_POS])
		else $error("program or erase started without busy");
endmodule : sfspi_front_sva
bind sfspi_front sfspi_front_sva #(.PUW_CYC(PUW_CYC)) sva_u (
	.sys_clk(sys_clk), .rst(rst), .chip_select_n(chip_select_n), .serial_clk(serial_clk),
	.bus_pause_n(bus_pause_n), .serial_io_oe(serial_io_oe), .serial_out_oe(serial_out_oe),
	.status_ff(status_ff), .powered_down_ff(powered_down_ff), .opcode_ff(opcode_ff),
	.paused_ff(paused_ff), .write_start_ff(write_start_ff)
);

// *** test/sfspi_master.sv ***
`timescale 1ns/10ps
module sfspi_master (
	input  wire logic       sys_clk,
	input  wire logic       do_line,
	input  wire logic       io_line,
	output logic            cs_n,
	output logic            sclk,
	output logic            mosi,
	output logic            hold_n,
	output logic      [7:0] rd_byte,
	output logic            rd_valid
);
	logic idle_hi;
	initial begin
		// Starts selected, so the first frame has no select fall
		cs_n = 1'b0;
		sclk = 1'b0;
		mosi = 1'b0;
		hold_n = 1'b1;
		idle_hi = 1'b0;
		rd_byte = 8'h00;
		rd_valid = 1'b0;
	end
	task automatic half();
		repeat (4) @(negedge sys_clk);
	endtask : half
	task automatic sel(input logic mode3);
		sclk = mode3;
		idle_hi = mode3;
		half();
		cs_n = 1'b0;
		half();
	endtask : sel
	task automatic desel();
		sclk = idle_hi;
		half();
		cs_n = 1'b1;
		mosi = ~mosi;
		half();
		half();
	endtask : desel
	task automatic tx(input logic [7:0] b, input int n);
		for (int i = 7; i > 7 - n; i--) begin
			sclk = 1'b0;
			mosi = b[i];
			half();
			sclk = 1'b1;
			half();
		end
	endtask : tx
	// Select stays low through the whole pause
	task automatic hold_gap();
		sclk = 1'b0;
		half();
		hold_n = 1'b0;
		half();
		repeat (2) begin
			sclk = 1'b1;
			mosi = ~mosi;
			half();
			sclk = 1'b0;
			half();
		end
		hold_n = 1'b1;
		half();
	endtask : hold_gap
	task automatic rx(input logic dual, output logic [7:0] b);
		for (int i = 7; i >= 0; i = i - 1 - dual) begin
			sclk = 1'b0;
			mosi = ~mosi;
			half();
			sclk = 1'b1;
			half();
			if (dual)
				b[i -: 2] = {io_line, do_line};
			else
				b[i] = do_line;
		end
		rd_byte = b;
		rd_valid = 1'b1;
		@(negedge sys_clk);
		rd_valid = 1'b0;
	endtask : rx
endmodule : sfspi_master

// *** test/tb_top.sv ***
`timescale 1ns/10ps
module tb_top;
	import sfspi_pkg::*;
	logic       sys_clk;
	logic       rst;
	logic       wp_n;
	logic [7:0] arr_data;
	logic       cs_n;
	logic       sclk;
	logic       mosi;
	logic       hold_n;
	logic       io_out;
	logic       io_oe;
	logic       so_pin;
	logic       so_oe;
	logic       do_last;
	logic       pd;
	logic [7:0] status;
	logic [7:0] rd_byte;
	logic       rd_valid;
	logic [7:0] d;
	logic [7:0] exp_q[$];
	int         fails = 0;
	int         num_checks = 0;
	wire logic  io_w = io_oe ? io_out : mosi;
	// Released data line shows the inverse of its last value
	wire logic  do_w = so_oe ? so_pin : ~do_last;
	sfspi_front #(.PUW_CYC(400), .WRITE_CYC(400)) dut_u (
		.sys_clk(sys_clk), .rst(rst), .chip_select_n(cs_n), .serial_clk(sclk),
		.bus_pause_n(hold_n), .write_protect_n(wp_n), .serial_io_in(io_w),
		.serial_io_out(io_out), .serial_io_oe(io_oe), .serial_out_pin(so_pin),
		.serial_out_oe(so_oe), .array_rd_data(arr_data), .array_addr(), .array_rd_strobe(),
		.array_wr_data(), .array_wr_strobe(), .status_ff(status), .powered_down_ff(pd),
		.opcode_ff(), .paused_ff(), .write_start_ff()
	);
	sfspi_master m_u (.sys_clk(sys_clk), .do_line(do_w), .io_line(io_w), .cs_n(cs_n),
		.sclk(sclk), .mosi(mosi), .hold_n(hold_n), .rd_byte(rd_byte), .rd_valid(rd_valid));
	initial begin
		sys_clk = 1'b0;
		forever #10 sys_clk = ~sys_clk;
	end
	always @(posedge sys_clk) begin
		if (so_oe === 1'b1)
			do_last <= so_pin;
		if (rd_valid === 1'b1)
			cmp(exp_q.pop_front(), rd_byte);
	end
	task automatic cmp(input logic [7:0] e, input logic [7:0] g);
		num_checks++;
		if (g !== e) begin
			fails++;
			$display("unexpected at %0t: got %h expected %h", $time, g, e);
		end
	endtask : cmp
	task automatic results();
		$display("checks %0d fails %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : results
	task automatic cmd(input logic [7:0] op, input logic m3, input int n);
		m_u.sel(m3);
		m_u.tx(op, n);
		m_u.desel();
	endtask : cmd
	task automatic wsr(input logic we, input logic [7:0] v);
		if (we)
			cmd(OP_WRITE_EN, 1'b0, 8);
		m_u.sel(1'b0);
		m_u.tx(OP_WRITE_STATUS, 8);
		m_u.tx(v, 8);
		m_u.desel();
	endtask : wsr
	task automatic idle();
		for (int n = 0; n < 1000 && status[BUSY_POS] !== 1'b0; n++)
			@(negedge sys_clk);
		if (status[BUSY_POS] !== 1'b0)
			fails++;
	endtask : idle
	task automatic rd(input logic [7:0] op, input logic dual, input int extra,
		input logic brk, input logic [7:0] e);
		logic [7:0] b;
		exp_q.push_back(e);
		m_u.sel(1'b0);
		m_u.tx(op, 4);
		if (brk)
			m_u.hold_gap();
		m_u.tx({op[3:0], 4'h0}, 4);
		for (int i = 0; i < extra; i++)
			m_u.tx(8'($urandom), 8);
		m_u.rx(dual, b);
		m_u.desel();
	endtask : rd
	initial begin
		void'($urandom(32'h0287));
		rst = 1'b1;
		wp_n = 1'b1;
		arr_data = 8'h00;
		do_last = 1'b0;
		repeat (3) @(negedge sys_clk);
		rst = 1'b0;
		@(negedge sys_clk);
		cmp(status, STATUS_RESET);
		cmd(OP_POWER_DOWN, 1'b0, 8);
		cmp({7'h00, pd}, 8'h00);
		cmd(OP_WRITE_EN, 1'b0, 8);
		cmp(status, 8'h00);
		repeat (300) @(negedge sys_clk);
		cmd(OP_WRITE_EN, 1'b1, 8);
		cmp(status, 8'h02);
		cmd(OP_WRITE_DIS, 1'b0, 8);
		cmp(status, 8'h00);
		wsr(1'b0, 8'h1C);
		cmp(status, 8'h00);
		d = (8'($urandom) & 8'hBC) | 8'h80;
		wsr(1'b1, d);
		cmp({7'h00, status[BUSY_POS]}, 8'h01);
		cmd(OP_WRITE_EN, 1'b0, 8);
		idle();
		cmp(status, d);
		rd(OP_READ_STATUS, 1'b0, 0, 1'b1, d);
		wp_n = 1'b0;
		wsr(1'b1, 8'h00);
		idle();
		cmp(status & 8'hBC, d & 8'hBC);
		wp_n = 1'b1;
		wsr(1'b1, 8'h00);
		idle();
		cmp(status, 8'h00);
		cmd(OP_WRITE_EN, 1'b1, 8);
		cmd(OP_CHIP_ERASE, 1'b1, 8);
		cmp({7'h00, status[BUSY_POS]}, 8'h01);
		idle();
		cmp(status, 8'h00);
		cmd(OP_WRITE_EN, 1'b0, 5);
		cmp(status, 8'h00);
		arr_data = 8'($urandom);
		rd(OP_READ_DATA, 1'b0, 3, 1'b0, arr_data);
		rd(OP_FAST_READ, 1'b0, 4, 1'b0, arr_data);
		rd(OP_DUAL_READ, 1'b1, 4, 1'b0, arr_data);
		cmd(OP_POWER_DOWN, 1'b0, 8);
		cmd(OP_WRITE_EN, 1'b0, 8);
		cmp({7'h00, pd}, 8'h01);
		cmp(status, 8'h00);
		cmd(OP_RELEASE_PD, 1'b0, 8);
		cmd(OP_WRITE_EN, 1'b0, 8);
		cmp(status, 8'h02);
		results();
	end
	initial begin
		#400_000;
		fails++;
		results();
	end
endmodule : tb_top
